// ===== src/drv_run_vf.sv
// Run-command, ramp and V/f profile logic of the motor drive.
`timescale 1ns/10ps
`default_nettype none
module drv_run_vf import drv_pkg::*; #(
	parameter int OL_UNIT_CYC = OL_UNIT_CYCLES,
	parameter int TICK_CYC = RAMP_TICK_CYCLES
) (
	// Clock and reset.
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// Run inputs from keypad and terminals (active high = closed).
	input wire logic FORWARD_RUN_INPUT_I,
	input wire logic REVERSE_RUN_INPUT_I,
	input wire logic RUN_KEY_I,
	input wire logic STOP_KEY_I,
	// Settings, loaded by a one-cycle write strobe, and the target frequency, read directly.
	input wire logic CFG_WRITE_I,
	input wire drv_cfg_t CFG_I,
	input wire logic [8:0] TARGET_FREQ_I,
	// Plant feedback.
	input wire logic [8:0] SUPPLY_VOLTAGE_I,
	input wire logic [7:0] CURRENT_PCT_I,
	input wire logic TORQUE_LIMIT_I,
	input wire logic [7:0] OL_TIME_CONST_I,
	// Outputs to the motor stage.
	output logic RUNNING_O,
	output logic DIRECTION_O,
	output logic [8:0] OUT_FREQ_O,
	output logic [8:0] OUT_VOLTAGE_O,
	output drv_curve_t BOOST_CURVE_O,
	output logic [4:0] BOOST_LEVEL_O,
	output logic OVERLOAD_TRIP_O,
	output logic CFG_REJECT_O
);

	// ***************************************************************
	// State
	// ***************************************************************

	// All state of the block in one record.
	typedef struct packed {
		drv_cfg_t cfg;
		drv_phase_t phase;
		logic run;
		logic dir;
		logic [8:0] freq;
		logic [8:0] volt;
		logic [31:0] tick;
		logic [18:0] step_cnt;
		logic [39:0] ol_cnt;
		logic trip;
		drv_curve_t curve;
		logic [4:0] level;
		logic reject;
	} drv_state_t;

	drv_state_t cur; // Registered state.
	drv_state_t nxt; // Next state.

	// Truncates a ramp time to its three leading decimal digits.
	function automatic logic [18:0] drv_sig3(input logic [18:0] v);
		logic [18:0] r;
		r = v;
		if (v >= 19'd100000) begin
			r = v - (v % 19'd1000);
		end else if (v >= 19'd10000) begin
			r = v - (v % 19'd100);
		end else if (v >= 19'd1000) begin
			r = v - (v % 19'd10);
		end
		return r;
	endfunction

	// ***************************************************************
	// Next-state logic
	// ***************************************************************

	// Combines command decode, ramp, voltage profile and overload.
	always_comb begin
		logic forward_run_input;
		logic reverse_run_input;
		logic one_dir;
		logic want_run;
		logic want_dir;
		logic [8:0] fmax;
		logic [8:0] tgt;
		logic [18:0] rtime;
		logic [8:0] vlim;
		logic [17:0] vprof;
		logic [39:0] ol_lim;
		logic ol_hot;
		forward_run_input = FORWARD_RUN_INPUT_I;
		reverse_run_input = REVERSE_RUN_INPUT_I;
		one_dir = 1'b0;
		want_run = 1'b0;
		want_dir = DIR_FWD;
		fmax = 9'h000;
		tgt = 9'h000;
		rtime = 19'h00000;
		vlim = 9'h000;
		vprof = 18'h00000;
		ol_lim = 40'h0;
		ol_hot = 1'b0;
		nxt = cur;
		nxt.reject = 1'b0;
		// Settings write; frequency, ramp and overload fields are range checked separately.
		if (CFG_WRITE_I) begin
			if (!forward_run_input && !reverse_run_input) begin
				nxt.cfg.run_command_source = CFG_I.run_command_source;
			end else begin
				nxt.reject = 1'b1;
			end
			if (CFG_I.max_frequency_setting >= MAX_FREQ_LOW &&
			    CFG_I.max_frequency_setting <= FREQ_HIGH) begin
				nxt.cfg.max_frequency_setting = CFG_I.max_frequency_setting;
			end
			if (CFG_I.base_frequency_setting >= BASE_FREQ_LOW &&
			    CFG_I.base_frequency_setting <= FREQ_HIGH) begin
				nxt.cfg.base_frequency_setting = CFG_I.base_frequency_setting;
			end
			nxt.cfg.rated_voltage_setting = CFG_I.rated_voltage_setting;
			nxt.cfg.max_voltage_setting = CFG_I.max_voltage_setting;
			// Each ramp time kept on its own, trimmed to three digits.
			if (CFG_I.accel_time_setting >= RAMP_LOW &&
			    CFG_I.accel_time_setting <= RAMP_HIGH) begin
				nxt.cfg.accel_time_setting =
					drv_sig3(CFG_I.accel_time_setting);
			end
			if (CFG_I.decel_time_setting >= RAMP_LOW &&
			    CFG_I.decel_time_setting <= RAMP_HIGH) begin
				nxt.cfg.decel_time_setting =
					drv_sig3(CFG_I.decel_time_setting);
			end
			nxt.cfg.torque_boost_select = CFG_I.torque_boost_select;
			if (CFG_I.overload_protect_select <= OL_FORCED) begin
				nxt.cfg.overload_protect_select =
					CFG_I.overload_protect_select;
			end
		end
		// Terminal direction decode; keypad and terminal sources need exactly one input closed.
		one_dir = forward_run_input ^ reverse_run_input;
		want_dir = reverse_run_input ? DIR_REV : DIR_FWD;
		want_run = cur.run;
		unique case (cur.cfg.run_command_source)
			SRC_KEYPAD: begin
				// Keys start and stop; terminals choose direction.
				if (STOP_KEY_I || !one_dir) begin
					want_run = 1'b0;
				end else if (RUN_KEY_I) begin
					want_run = 1'b1;
				end
			end
			SRC_TERMINAL: begin
				want_run = one_dir;
			end
			SRC_KEY_FWD: begin
				want_dir = DIR_FWD;
				if (STOP_KEY_I) begin
					want_run = 1'b0;
				end else if (RUN_KEY_I) begin
					want_run = 1'b1;
				end
			end
			SRC_KEY_REV: begin
				want_dir = DIR_REV;
				if (STOP_KEY_I) begin
					want_run = 1'b0;
				end else if (RUN_KEY_I) begin
					want_run = 1'b1;
				end
			end
		endcase
		nxt.run = want_run;
		// Direction is only changed once the output has ramped to zero.
		if (cur.freq == 9'h000) begin
			nxt.dir = want_dir;
		end
		// Target frequency, capped at maximum frequency.
		fmax = cur.cfg.max_frequency_setting;
		tgt = (TARGET_FREQ_I > fmax) ? fmax : TARGET_FREQ_I;
		if (!cur.run || cur.dir != want_dir) begin
			tgt = 9'h000;
		end
		// Ramp phase selection.
		if (cur.freq < tgt) begin
			nxt.phase = DRV_ACCEL;
		end else if (cur.freq > tgt) begin
			nxt.phase = DRV_DECEL;
		end else begin
			nxt.phase = (tgt == 9'h000) ? DRV_IDLE : DRV_HOLD;
		end
		// One 1 Hz step per (ramp time / fmax); a full swing takes the
		// setting, a partial swing proportionally less.
		rtime = (nxt.phase == DRV_DECEL) ? cur.cfg.decel_time_setting :
			cur.cfg.accel_time_setting;
		nxt.tick = (cur.tick >= 32'(TICK_CYC - 1)) ? 32'h0 :
			cur.tick + 32'h1;
		if (cur.tick >= 32'(TICK_CYC - 1) && !TORQUE_LIMIT_I) begin
			nxt.step_cnt = cur.step_cnt + 19'(fmax);
		end
		if (nxt.step_cnt >= rtime) begin
			nxt.step_cnt = 19'h0;
			if (nxt.phase == DRV_ACCEL) begin
				nxt.freq = cur.freq + 9'h001;
			end else if (nxt.phase == DRV_DECEL) begin
				nxt.freq = cur.freq - 9'h001;
			end
		end
		if (nxt.phase == DRV_IDLE || nxt.phase == DRV_HOLD) begin
			nxt.step_cnt = 19'h0;
		end
		// Voltage profile: linear to base frequency, then flat.
		vlim = cur.cfg.rated_voltage_setting;
		if (vlim > cur.cfg.max_voltage_setting) begin
			vlim = cur.cfg.max_voltage_setting;
		end
		if (cur.cfg.rated_voltage_setting == 9'h000) begin
			vlim = SUPPLY_VOLTAGE_I;
		end
		if (cur.freq >= cur.cfg.base_frequency_setting) begin
			vprof = {9'h000, vlim};
		end else begin
			// Both factors are widened first, so the product cannot wrap.
			vprof = (18'(vlim) * 18'(cur.freq)) /
				18'(cur.cfg.base_frequency_setting);
		end
		nxt.volt = (vprof > {9'h000, SUPPLY_VOLTAGE_I}) ? SUPPLY_VOLTAGE_I :
			vprof[8:0];
		// Boost curve decode.
		unique case (cur.cfg.torque_boost_select)
			BOOST_AUTO: nxt.curve = DRV_CURVE_AUTO;
			BOOST_SQUARE: nxt.curve = DRV_CURVE_SQUARE;
			BOOST_PROP: nxt.curve = DRV_CURVE_PROP;
			default: nxt.curve = DRV_CURVE_CONST;
		endcase
		nxt.level = cur.cfg.torque_boost_select;
		// Overload timer: counts while current is at or above the trip
		// level; general motors derate below half base frequency.
		ol_lim = 40'(OL_UNIT_CYC) * 40'(OL_TIME_CONST_I);
		ol_hot = CURRENT_PCT_I >= OL_TRIP_PCT;
		if (cur.cfg.overload_protect_select == OL_GENERAL &&
		    {cur.freq, 1'b0} < {1'b0, cur.cfg.base_frequency_setting}) begin
			ol_hot = CURRENT_PCT_I >= PCT_FULL;
		end
		if (cur.cfg.overload_protect_select == OL_OFF) begin
			nxt.ol_cnt = 40'h0;
		end else if (ol_hot) begin
			if (cur.ol_cnt < ol_lim) begin
				nxt.ol_cnt = cur.ol_cnt + 40'h1;
			end else begin
				nxt.trip = 1'b1;
			end
		end else begin
			nxt.ol_cnt = 40'h0;
		end
		// Trip stops the drive until reset.
		if (cur.trip) begin
			nxt.run = 1'b0;
		end
	end

	// ***************************************************************
	// State register
	// ***************************************************************

	// Registers the state record with a synchronous reset.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			cur <= '0;
			cur.cfg.max_frequency_setting <= MAX_FREQ_RESET;
			cur.cfg.base_frequency_setting <= BASE_FREQ_RESET;
			cur.cfg.accel_time_setting <= RAMP_RESET;
			cur.cfg.decel_time_setting <= RAMP_RESET;
			cur.cfg.overload_protect_select <= OL_GENERAL;
		end else begin
			cur <= nxt;
		end
	end

	// Outputs straight from the state record.
	assign RUNNING_O = cur.run;
	assign DIRECTION_O = cur.dir;
	assign OUT_FREQ_O = cur.freq;
	assign OUT_VOLTAGE_O = cur.volt;
	assign BOOST_CURVE_O = cur.curve;
	assign BOOST_LEVEL_O = cur.level;
	assign OVERLOAD_TRIP_O = cur.trip;
	assign CFG_REJECT_O = cur.reject;

endmodule
`default_nettype wire

// ===== src/drv_pkg.sv
// Package of constants and carrier types for the drive run and V/f block.
package drv_pkg;

	// ***************************************************************
	// Setting ranges and encodings
	// ***************************************************************

	// Run-command source codes.
	localparam logic [1:0] SRC_KEYPAD = 2'h0;
	localparam logic [1:0] SRC_TERMINAL = 2'h1;
	localparam logic [1:0] SRC_KEY_FWD = 2'h2;
	localparam logic [1:0] SRC_KEY_REV = 2'h3;

	// Frequency limits in whole hertz.
	localparam logic [8:0] MAX_FREQ_LOW = 9'h032;
	localparam logic [8:0] BASE_FREQ_LOW = 9'h019;
	localparam logic [8:0] FREQ_HIGH = 9'h190;
	localparam logic [8:0] MAX_FREQ_RESET = 9'h032;
	localparam logic [8:0] BASE_FREQ_RESET = 9'h032;

	// Ramp time limits in units of 0.01 s.
	localparam logic [18:0] RAMP_LOW = 19'h00001;
	localparam logic [18:0] RAMP_HIGH = 19'h57e40;
	localparam logic [18:0] RAMP_RESET = 19'h00258;

	// Ramp time unit and the derived tick count per 0.01 s.
	localparam int CLK_HZ = 10000000;
	localparam int RAMP_UNIT_MS = 10;
	localparam int RAMP_TICK_CYCLES = CLK_HZ / 1000 * RAMP_UNIT_MS;

	// Torque boost curve codes.
	localparam logic [4:0] BOOST_AUTO = 5'h00;
	localparam logic [4:0] BOOST_SQUARE = 5'h01;
	localparam logic [4:0] BOOST_PROP = 5'h02;

	// Overload protection select codes.
	localparam logic [1:0] OL_OFF = 2'h0;
	localparam logic [1:0] OL_GENERAL = 2'h1;
	localparam logic [1:0] OL_FORCED = 2'h2;

	// Overload trip level as a percentage of the configured level.
	localparam logic [7:0] OL_TRIP_PCT = 8'h96;
	localparam logic [7:0] PCT_FULL = 8'h64;

	// Overload time constant unit is 0.1 min, i.e. 6 s.
	localparam int OL_UNIT_S = 6;
	localparam int OL_UNIT_CYCLES = CLK_HZ * OL_UNIT_S;

	// Direction encoding.
	localparam logic DIR_FWD = 1'b0;
	localparam logic DIR_REV = 1'b1;

	// ***************************************************************
	// Carrier types
	// ***************************************************************

	// Boost curve decoded from the select code.
	typedef enum logic [1:0] {
		DRV_CURVE_AUTO = 2'b00,
		DRV_CURVE_SQUARE = 2'b01,
		DRV_CURVE_PROP = 2'b10,
		DRV_CURVE_CONST = 2'b11
	} drv_curve_t;

	// Ramp phase of the frequency generator.
	typedef enum logic [1:0] {
		DRV_IDLE = 2'b00,
		DRV_ACCEL = 2'b01,
		DRV_DECEL = 2'b10,
		DRV_HOLD = 2'b11
	} drv_phase_t;

	// Settings as held inside the block.
	typedef struct packed {
		logic [1:0] run_command_source;
		logic [8:0] max_frequency_setting;
		logic [8:0] base_frequency_setting;
		logic [8:0] rated_voltage_setting;
		logic [8:0] max_voltage_setting;
		logic [18:0] accel_time_setting;
		logic [18:0] decel_time_setting;
		logic [4:0] torque_boost_select;
		logic [1:0] overload_protect_select;
	} drv_cfg_t;

endpackage

// ===== verif/drv_checker.sv
// Concurrent checks on the ports of the run and V/f block.
`timescale 1ns/10ps
`default_nettype none
module drv_checker import drv_pkg::*; (
	// Clock, reset and watched inputs.
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic FORWARD_RUN_INPUT_I,
	input wire logic REVERSE_RUN_INPUT_I,
	input wire logic RUN_KEY_I,
	input wire logic CFG_WRITE_I,
	input wire logic [8:0] SUPPLY_VOLTAGE_I,
	input wire logic TORQUE_LIMIT_I,
	// Watched outputs.
	input wire logic RUNNING_O,
	input wire logic DIRECTION_O,
	input wire logic [8:0] OUT_FREQ_O,
	input wire logic [8:0] OUT_VOLTAGE_O,
	input wire drv_curve_t BOOST_CURVE_O,
	input wire logic [4:0] BOOST_LEVEL_O,
	input wire logic OVERLOAD_TRIP_O,
	input wire logic CFG_REJECT_O
);
	// ****************************************
	// Port checks
	// ****************************************
	// Every check runs on the one clock and rests during reset.
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	reject_cause_a: assert property (
		CFG_WRITE_I && (FORWARD_RUN_INPUT_I || REVERSE_RUN_INPUT_I)
		|=> CFG_REJECT_O) else $error("write not refused");
	reject_only_a: assert property (
		CFG_REJECT_O |-> $past(CFG_WRITE_I) &&
		($past(FORWARD_RUN_INPUT_I) || $past(REVERSE_RUN_INPUT_I)))
		else $error("refusal without cause");
	start_cause_a: assert property (
		$rose(RUNNING_O) |-> $past(RUN_KEY_I) ||
		($past(FORWARD_RUN_INPUT_I) ^ $past(REVERSE_RUN_INPUT_I)))
		else $error("start without a single run input");
	start_dir_a: assert property (
		$rose(RUNNING_O) && !$past(RUN_KEY_I)
		|-> DIRECTION_O == $past(REVERSE_RUN_INPUT_I))
		else $error("bad direction");
	freq_cap_a: assert property (OUT_FREQ_O <= FREQ_HIGH)
		else $error("frequency above ceiling");
	volt_supply_a: assert property (
		$stable(SUPPLY_VOLTAGE_I) [*2]
		|-> OUT_VOLTAGE_O <= SUPPLY_VOLTAGE_I)
		else $error("voltage above supply");
	boost_decode_a: assert property (
		BOOST_CURVE_O == ((BOOST_LEVEL_O > 5'h02) ? DRV_CURVE_CONST :
		drv_curve_t'(BOOST_LEVEL_O[1:0]))) else $error("bad curve");
	trip_sticky_a: assert property (
		OVERLOAD_TRIP_O |=> OVERLOAD_TRIP_O) else $error("trip dropped");
	freq_step_a: assert property (
		OUT_FREQ_O == $past(OUT_FREQ_O) ||
		OUT_FREQ_O == $past(OUT_FREQ_O) + 9'h001 ||
		OUT_FREQ_O == $past(OUT_FREQ_O) - 9'h001)
		else $error("frequency jumped");
	stall_hold_a: assert property (
		TORQUE_LIMIT_I [*2] |-> $stable(OUT_FREQ_O))
		else $error("ramp moved under torque limit");
endmodule
`default_nettype wire

// ===== verif/drv_motor_model.sv
// Behavioural motor and mains supply on the far side of the block.
`timescale 1ns/10ps
`default_nettype none
module drv_motor_model #(
	parameter logic [8:0] SUPPLY = 9'h0e6
) (
	// Drive state and load commanded by the bench.
	input wire logic running_i,
	input wire logic [7:0] load_i,
	input wire logic stall_i,
	// Feedback towards the block.
	output logic [8:0] supply_o,
	output logic [7:0] current_o,
	output logic torque_limit_o
);
	// The mains level is fixed in this model.
	assign supply_o = SUPPLY;
	// An idle motor draws no current, so a load only shows while driven.
	assign current_o = running_i ? load_i : 8'h00;
	// A stall can only hold the limiter while the motor is driven.
	assign torque_limit_o = stall_i & running_i;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking testbench of the run and V/f block.
`timescale 1ns/10ps
`default_nettype none
module tb_top import drv_pkg::*;;
	// Stimulus, feedback and observed outputs.
	logic clk, rst_n, forward_run_input, reverse_run_input, run_k, stop_k, cfg_wr, stall, tq;
	logic running, dir, trip, rej;
	logic [8:0] tgt, supply, freq, volt;
	logic [7:0] cur, load, olt;
	logic [4:0] lvl;
	drv_cfg_t cfg;
	drv_curve_t curve;
	int num_errors, tests_run, wait_n;
	// ****************************************
	// Design, far side and clock
	// ****************************************
	drv_run_vf #(.OL_UNIT_CYC(4), .TICK_CYC(10)) u_drv_run_vf (.CLK_I(clk),
		.RST_N_I(rst_n), .FORWARD_RUN_INPUT_I(forward_run_input), .REVERSE_RUN_INPUT_I(reverse_run_input),
		.RUN_KEY_I(run_k), .STOP_KEY_I(stop_k), .CFG_WRITE_I(cfg_wr), .CFG_I(cfg),
		.TARGET_FREQ_I(tgt), .SUPPLY_VOLTAGE_I(supply), .CURRENT_PCT_I(cur),
		.TORQUE_LIMIT_I(tq), .OL_TIME_CONST_I(olt), .RUNNING_O(running),
		.DIRECTION_O(dir), .OUT_FREQ_O(freq), .OUT_VOLTAGE_O(volt),
		.BOOST_CURVE_O(curve), .BOOST_LEVEL_O(lvl), .OVERLOAD_TRIP_O(trip),
		.CFG_REJECT_O(rej));
	drv_motor_model u_drv_motor_model (.running_i(running), .load_i(load),
		.stall_i(stall), .supply_o(supply), .current_o(cur), .torque_limit_o(tq));
	// A 100 ns clock period.
	always #50 clk = ~clk;
	// ****************************************
	// Shared tasks
	// ****************************************
	// Compares one value and counts the result.
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Sends the settings with a one-cycle strobe. It returns in the cycle
	// in which a refusal shows; outputs follow the settings a cycle on.
	task automatic wr();
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	// Waits, bounded, until the output frequency reaches a value.
	task automatic wait_for(input logic [8:0] exp);
		wait_n = 0;
		while (freq !== exp && wait_n < 3000) begin
			@(negedge clk);
			wait_n++;
		end
		chk(freq, exp);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	// Every boost code class, including both ends of the constant range.
	task automatic t_boost();
		logic [4:0] c [5] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1f};
		drv_curve_t e [5] = '{DRV_CURVE_AUTO, DRV_CURVE_SQUARE, DRV_CURVE_PROP,
			DRV_CURVE_CONST, DRV_CURVE_CONST};
		for (int i = 0; i < 5; i++) begin
			cfg.torque_boost_select = c[i];
			wr();
			@(negedge clk);
			chk(curve, e[i]);
			chk(lvl, c[i]);
		end
	endtask
	// Source change refused with a terminal closed, then terminal running.
	task automatic t_run();
		logic [8:0] f;
		forward_run_input = 1'b1;
		cfg.run_command_source = SRC_TERMINAL;
		wr();
		chk(rej, 1'b1);
		repeat (3) @(negedge clk);
		chk(running, 1'b0);
		forward_run_input = 1'b0;
		@(negedge clk);
		wr();
		chk(rej, 1'b0);
		forward_run_input = 1'b1;
		reverse_run_input = 1'b1;
		repeat (3) @(negedge clk);
		chk(running, 1'b0);
		reverse_run_input = 1'b0;
		repeat (2) @(negedge clk);
		chk(running, 1'b1);
		chk(dir, DIR_FWD);
		wait_for(9'h00a);
		chk(9'(wait_n > 79 && wait_n < 141), 9'h001);
		// An out-of-range maximum is dropped, so 50 Hz still caps 60 Hz.
		cfg.max_frequency_setting = 9'h028;
		tgt = 9'h03c;
		wr();
		cfg.max_frequency_setting = 9'h032;
		repeat (20) @(negedge clk);
		f = freq;
		stall = 1'b1;
		repeat (40) @(negedge clk);
		chk(freq, f);
		stall = 1'b0;
		wait_for(9'h032);
		repeat (100) @(negedge clk);
		chk(freq, 9'h032);
	endtask
	// Voltage at base frequency for one pair of voltage settings.
	task automatic vcase(input logic [8:0] r, input logic [8:0] m,
		input logic [8:0] e);
		cfg.rated_voltage_setting = r;
		cfg.max_voltage_setting = m;
		wr();
		repeat (3) @(negedge clk);
		chk(volt, e);
	endtask
	// Keypad start, direction and decelerated stop for one source code.
	task automatic keys(input logic [1:0] src, input logic d);
		cfg.run_command_source = src;
		wr();
		reverse_run_input = (src == SRC_KEYPAD);
		run_k = 1'b1;
		@(negedge clk);
		run_k = 1'b0;
		repeat (2) @(negedge clk);
		chk(running, 1'b1);
		chk(dir, d);
		wait_for(9'h00a);
		stop_k = 1'b1;
		@(negedge clk);
		stop_k = 1'b0;
		@(negedge clk);
		chk(9'(freq == 9'h000), 9'h000);
		wait_for(9'h000);
		repeat (3) @(negedge clk);
		chk(running, 1'b0);
		reverse_run_input = 1'b0;
	endtask
	// Ramp time range and digit trimming, and base frequency range, seen
	// through the spacing of steps and the voltage below base frequency.
	task automatic t_ramp();
		cfg.run_command_source = SRC_TERMINAL;
		cfg.accel_time_setting = 19'h00000;
		cfg.base_frequency_setting = 9'h018;
		wr();
		forward_run_input = 1'b1;
		wait_for(9'h001);
		wait_for(9'h002);
		// The kept 0.50 s setting steps once per tick of 10 cycles.
		chk(9'(wait_n > 5 && wait_n < 15), 9'h001);
		wait_for(9'h00a);
		repeat (3) @(negedge clk);
		// Rated 400 V scaled by 10 Hz over the kept 50 Hz base.
		chk(volt, 9'h050);
		cfg.base_frequency_setting = 9'h019;
		cfg.accel_time_setting = 19'h003f1;
		wr();
		repeat (3) @(negedge clk);
		chk(volt, 9'h0a0);
		// 10.09 s is kept as 10.0 s: 20 ticks of 10 cycles per hertz.
		tgt = 9'h00c;
		wait_for(9'h00b);
		wait_for(9'h00c);
		chk(9'(wait_n > 190 && wait_n < 206), 9'h001);
		forward_run_input = 1'b0;
		cfg.accel_time_setting = 19'h00032;
		cfg.base_frequency_setting = 9'h032;
		tgt = 9'h00a;
		wr();
		wait_for(9'h000);
	endtask
	// Overload off, forced-ventilated threshold, stickiness and reset.
	task automatic t_ol();
		cfg.run_command_source = SRC_TERMINAL;
		cfg.overload_protect_select = OL_OFF;
		wr();
		forward_run_input = 1'b1;
		load = 8'hc8;
		repeat (40) @(negedge clk);
		chk(trip, 1'b0);
		load = 8'h00;
		cfg.overload_protect_select = OL_FORCED;
		wr();
		load = 8'h95;
		repeat (40) @(negedge clk);
		chk(trip, 1'b0);
		load = 8'h96;
		repeat (12) @(negedge clk);
		chk(trip, 1'b1);
		load = 8'h00;
		repeat (4) @(negedge clk);
		chk(trip, 1'b1);
		rst_n = 1'b0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(trip, 1'b0);
		// A general motor below half base frequency trips at 100%.
		forward_run_input = 1'b0;
		cfg.overload_protect_select = OL_GENERAL;
		wr();
		forward_run_input = 1'b1;
		load = 8'h64;
		repeat (14) @(negedge clk);
		chk(trip, 1'b1);
	endtask
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	// Resets the block, then runs the scenarios in order.
	initial begin
		{clk, rst_n, forward_run_input, reverse_run_input, run_k, stop_k, cfg_wr, stall} = 8'h00;
		num_errors = 0;
		tests_run = 0;
		wait_n = 0;
		load = 8'h00;
		olt = 8'h02;
		tgt = 9'h00a;
		cfg = '0;
		cfg.max_frequency_setting = 9'h032;
		cfg.base_frequency_setting = 9'h032;
		cfg.max_voltage_setting = 9'h1e0;
		cfg.accel_time_setting = 19'h00032;
		cfg.decel_time_setting = 19'h00032;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		chk(running, 1'b0);
		chk(freq, 9'h000);
		t_boost();
		t_run();
		vcase(9'h000, 9'h1e0, 9'h0e6);
		vcase(9'h0c8, 9'h064, 9'h064);
		vcase(9'h190, 9'h1e0, 9'h0e6);
		forward_run_input = 1'b0;
		wait_for(9'h000);
		tgt = 9'h00a;
		keys(SRC_KEY_FWD, DIR_FWD);
		keys(SRC_KEY_REV, DIR_REV);
		keys(SRC_KEYPAD, DIR_REV);
		t_ramp();
		t_ol();
		end_of_test();
	end
	// Cuts a hang short well after the expected run length.
	initial begin
		#2000000;
		num_errors++;
		end_of_test();
	end
endmodule
bind drv_run_vf drv_checker u_drv_checker (.CLK_I, .RST_N_I,
	.FORWARD_RUN_INPUT_I, .REVERSE_RUN_INPUT_I, .RUN_KEY_I, .CFG_WRITE_I,
	.SUPPLY_VOLTAGE_I, .TORQUE_LIMIT_I, .RUNNING_O, .DIRECTION_O, .OUT_FREQ_O,
	.OUT_VOLTAGE_O, .BOOST_CURVE_O, .BOOST_LEVEL_O, .OVERLOAD_TRIP_O,
	.CFG_REJECT_O);
`default_nettype wire
